// ---- verilog/aic_pkg.sv ----
// Constants for the per-axis interrupt cause logic.
// Assumes one reference clock and a command port that carries read and write commands.
package aic_pkg;

    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int NUM_AXES = 4;
    localparam int AXIS_W   = 2;
    localparam int DATA_W   = 32;
    localparam int CMD_W    = 8;
    localparam int ERR_W    = 18;
    localparam int EN_W     = 19;
    localparam int STAT_W   = 20;

    // ------------------------------------------------------------------
    // Command codes
    // ------------------------------------------------------------------
    localparam logic [CMD_W-1:0] CMD_RD_ERR_CAUSE   = 8'hf2;
    localparam logic [CMD_W-1:0] CMD_RD_EVT_STATUS  = 8'hf3;
    localparam logic [CMD_W-1:0] CMD_WR_EVT_ENABLE  = 8'hac;
    localparam logic [CMD_W-1:0] CMD_WR_ENV_ONE     = 8'h9c;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int ERR_UNDEF_BIT   = 11;
    localparam int ENV_INTMASK_BIT = 29;
    localparam int EN_DIR_BIT      = 17;
    localparam int EN_START_BIT    = 18;
    localparam int ST_DIR_PLUS     = 17;
    localparam int ST_DIR_MINUS    = 18;
    localparam int ST_START_BIT    = 19;

    // ------------------------------------------------------------------
    // Cause bit positions
    // ------------------------------------------------------------------
    localparam int ERR_CMP_FIRST_BIT    = 0;
    localparam int ERR_CMP_LAST_BIT     = 4;
    localparam int ERR_ALARM_BIT        = 7;
    localparam int ERR_SLOW_DOWN_BIT    = 10;
    localparam int ERR_BAD_DATA_BIT     = 12;
    localparam int ERR_CO_STOP_BIT      = 13;
    localparam int ERR_PULSER_OVF_BIT   = 14;
    localparam int ERR_OVER_RANGE_BIT   = 15;
    localparam int ERR_ENC_PHASE_BIT    = 16;
    localparam int ERR_PULSER_PHASE_BIT = 17;
    localparam int ST_PREREG_FIRST_BIT  = 2;
    localparam int ST_PREREG_LAST_BIT   = 3;
    localparam int ST_CMP_FIRST_BIT     = 8;
    localparam int ST_CMP_LAST_BIT      = 12;
    localparam int ST_CLEAR_BIT         = 13;
    localparam int ST_LATCH_BIT         = 14;
    localparam int ST_ORIGIN_BIT        = 15;
    localparam int ST_SLOW_DOWN_BIT     = 16;

    // Defined error cause bits 0..17; only bit 11 stays zero.
    localparam logic [ERR_W-1:0]  ERR_VALID_MASK = 18'h3f7ff;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [ERR_W-1:0]  ERR_RESET    = 18'h00000;
    localparam logic [EN_W-1:0]   EN_RESET     = 19'h00000;
    localparam logic [STAT_W-1:0] STAT_RESET   = 20'h00000;
    localparam logic              MASK_RESET   = 1'b0;

endpackage : aic_pkg

// ---- verilog/aic_axis_interrupt_cause.sv ----
// Per-axis interrupt cause registers, event enables and the shared interrupt pin.
// Assumes cause pulses from the motion logic and commands synchronous to clk.
`timescale 1ns/10ps

module aic_axis_interrupt_cause
    import aic_pkg::*;
(
    input  wire logic                            clk,
    input  wire logic                            reset,
    input  wire logic                            ce,
    input  wire logic [NUM_AXES-1:0][ERR_W-1:0]  err_cause_in,
    input  wire logic [NUM_AXES-1:0][STAT_W-1:0] evt_cause_in,
    input  wire logic                            cmd_valid,
    input  wire logic [AXIS_W-1:0]               cmd_axis,
    input  wire logic [CMD_W-1:0]                cmd_code,
    input  wire logic [DATA_W-1:0]               cmd_wdata,
    output logic                                 rd_valid,
    output logic [DATA_W-1:0]                    rd_data,
    output logic [NUM_AXES-1:0]                  err_flag,
    output logic [NUM_AXES-1:0]                  evt_flag,
    output logic                                 int_n
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [NUM_AXES-1:0][ERR_W-1:0]  error_cause;
        logic [NUM_AXES-1:0][EN_W-1:0]   event_enable;
        logic [NUM_AXES-1:0][STAT_W-1:0] event_status;
        logic                            int_mask;
        logic                            int_n;
        logic                            rd_valid;
        logic [DATA_W-1:0]               rd_data;
        logic [NUM_AXES-1:0]             err_flag;
        logic [NUM_AXES-1:0]             evt_flag;
    } aic_state_type;

    localparam aic_state_type STATE_RESET = '{
        error_cause:  {NUM_AXES{ERR_RESET}},
        event_enable: {NUM_AXES{EN_RESET}},
        event_status: {NUM_AXES{STAT_RESET}},
        int_mask:     MASK_RESET,
        int_n:        1'b1,
        rd_valid:     1'b0,
        rd_data:      '0,
        err_flag:     '0,
        evt_flag:     '0
    };

    aic_state_type state_reg;
    aic_state_type state_next;

    logic [NUM_AXES-1:0][ERR_W-1:0]  err_set;
    logic [NUM_AXES-1:0][STAT_W-1:0] en_expand;
    logic [NUM_AXES-1:0]             err_pend;
    logic [NUM_AXES-1:0]             evt_pend;
    logic [NUM_AXES-1:0]             clr_err;
    logic [NUM_AXES-1:0]             clr_evt;
    logic [NUM_AXES-1:0]             wr_en;
    logic                            any_pend;
    logic                            wr_env;

    // ------------------------------------------------------------------
    // Per-axis cause decode
    // ------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < NUM_AXES; g++) begin : g_axis
            // Error bits 0..17 land in place; undefined bit 11 is dropped.
            assign err_set[g] = err_cause_in[g] & ERR_VALID_MASK;
            // One enable bit covers both direction changes.
            assign en_expand[g] = {state_reg.event_enable[g][EN_START_BIT],
                                   state_reg.event_enable[g][EN_DIR_BIT],
                                   state_reg.event_enable[g][EN_DIR_BIT:0]};
            assign err_pend[g] = |state_reg.error_cause[g];
            assign evt_pend[g] = |(state_reg.event_status[g] & en_expand[g]);
            assign clr_err[g] = cmd_valid && (cmd_axis == AXIS_W'(g))
                                && (cmd_code == CMD_RD_ERR_CAUSE);
            assign clr_evt[g] = cmd_valid && (cmd_axis == AXIS_W'(g))
                                && (cmd_code == CMD_RD_EVT_STATUS);
            assign wr_en[g] = cmd_valid && (cmd_axis == AXIS_W'(g))
                              && (cmd_code == CMD_WR_EVT_ENABLE);
        end
    endgenerate

    assign any_pend = (|err_pend) | (|evt_pend);
    assign wr_env   = cmd_valid && (cmd_code == CMD_WR_ENV_ONE);

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        if (ce) begin
            state_next.rd_valid = 1'b0;
            for (int a = 0; a < NUM_AXES; a++) begin
                // A new cause in the clearing cycle survives the clear.
                state_next.error_cause[a] = (state_reg.error_cause[a]
                                             & ~{ERR_W{clr_err[a]}})
                                            | err_set[a];
                // All events latch in status regardless of enable.
                state_next.event_status[a] = (state_reg.event_status[a]
                                              & ~{STAT_W{clr_evt[a]}})
                                             | evt_cause_in[a];
                if (wr_en[a]) begin
                    state_next.event_enable[a] = cmd_wdata[EN_W-1:0];
                end
                state_next.err_flag[a] = |state_next.error_cause[a];
                state_next.evt_flag[a] = |(state_next.event_status[a] & en_expand[a]);
            end
            if (wr_env) begin
                state_next.int_mask = cmd_wdata[ENV_INTMASK_BIT];
            end
            if (cmd_valid && cmd_code == CMD_RD_ERR_CAUSE) begin
                state_next.rd_valid = 1'b1;
                state_next.rd_data  = DATA_W'(state_reg.error_cause[cmd_axis]);
            end else if (cmd_valid && cmd_code == CMD_RD_EVT_STATUS) begin
                state_next.rd_valid = 1'b1;
                state_next.rd_data  = DATA_W'(state_reg.event_status[cmd_axis]);
            end
            // Pin follows the registered causes, so status always leads it.
            state_next.int_n = !(any_pend && !state_reg.int_mask);
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            state_reg <= STATE_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    assign rd_valid = state_reg.rd_valid;
    assign rd_data  = state_reg.rd_data;
    assign err_flag = state_reg.err_flag;
    assign evt_flag = state_reg.evt_flag;
    assign int_n    = state_reg.int_n;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    logic [ERR_W-1:0]  sel_err;
    logic [STAT_W-1:0] sel_evt;
    logic [NUM_AXES-1:0][ERR_W-1:0] err_undef;

    assign sel_err = state_reg.error_cause[cmd_axis];
    assign sel_evt = state_reg.event_status[cmd_axis];

    generate
        for (g = 0; g < NUM_AXES; g++) begin : g_chk
            assign err_undef[g] = state_reg.error_cause[g] & ~ERR_VALID_MASK;
        end
    endgenerate

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    property p_err_set;
        ce |=> ((state_reg.error_cause & $past(err_set)) == $past(err_set));
    endproperty
    a_err_set: assert property (p_err_set) else $error("Error cause was lost.");

    property p_err_undef;
        err_undef == '0;
    endproperty
    a_err_undef: assert property (p_err_undef) else $error("Undefined error bit set.");

    property p_evt_set;
        ce |=> ((state_reg.event_status & $past(evt_cause_in)) == $past(evt_cause_in));
    endproperty
    a_evt_set: assert property (p_evt_set) else $error("Event status was lost.");

    property p_rd_err;
        ce && cmd_valid && cmd_code == CMD_RD_ERR_CAUSE
            |=> rd_valid && rd_data == DATA_W'($past(sel_err));
    endproperty
    a_rd_err: assert property (p_rd_err) else $error("Error read data wrong.");

    property p_rd_evt_clear;
        ce && cmd_valid && cmd_code == CMD_RD_EVT_STATUS
            && evt_cause_in[cmd_axis] == '0
            |=> rd_data == DATA_W'($past(sel_evt))
                && state_reg.event_status[$past(cmd_axis)] == '0;
    endproperty
    a_rd_evt_clear: assert property (p_rd_evt_clear) else $error("Status not cleared.");

    property p_int_low;
        ce && any_pend && !state_reg.int_mask |=> !int_n;
    endproperty
    a_int_low: assert property (p_int_low) else $error("Interrupt not asserted.");

    property p_int_high;
        ce && !any_pend |=> int_n;
    endproperty
    a_int_high: assert property (p_int_high) else $error("Interrupt without cause.");

    property p_mask;
        ce && state_reg.int_mask |=> int_n;
    endproperty
    a_mask: assert property (p_mask) else $error("Masked interrupt reached pin.");

    property p_status_first;
        ce && !any_pend && int_n && (|err_set) |=> int_n ##0 any_pend;
    endproperty
    a_status_first: assert property (p_status_first) else $error("Pin led status.");

    property p_dir_enable;
        state_reg.event_status[0][ST_DIR_MINUS] && state_reg.event_enable[0][EN_DIR_BIT]
            |-> any_pend;
    endproperty
    a_dir_enable: assert property (p_dir_enable) else $error("Direction enable ignored.");

    property p_start_enable;
        state_reg.event_status[0][ST_START_BIT] && state_reg.event_enable[0][EN_START_BIT]
            |-> evt_pend[0];
    endproperty
    a_start_enable: assert property (p_start_enable) else $error("Start enable ignored.");

    // ------------------------------------------------------------------
    // Per-axis cause mapping checks
    // ------------------------------------------------------------------
    generate
        for (g = 0; g < NUM_AXES; g++) begin : g_rule
            property p_cmp_stop;
                ce |=> ($past(err_cause_in[g][ERR_CMP_LAST_BIT:ERR_CMP_FIRST_BIT])
                        & ~state_reg.error_cause[g][ERR_CMP_LAST_BIT:ERR_CMP_FIRST_BIT])
                       == '0;
            endproperty
            a_cmp_stop: assert property (p_cmp_stop) else $error("Error bit lost.");

            property p_alarm_stop;
                ce && err_cause_in[g][ERR_ALARM_BIT]
                    |=> state_reg.error_cause[g][ERR_ALARM_BIT];
            endproperty
            a_alarm_stop: assert property (p_alarm_stop) else $error("Error bit lost.");

            property p_slow_stop;
                ce && err_cause_in[g][ERR_SLOW_DOWN_BIT]
                    |=> state_reg.error_cause[g][ERR_SLOW_DOWN_BIT];
            endproperty
            a_slow_stop: assert property (p_slow_stop) else $error("Error bit lost.");

            property p_data_stop;
                ce && err_cause_in[g][ERR_BAD_DATA_BIT]
                    |=> state_reg.error_cause[g][ERR_BAD_DATA_BIT];
            endproperty
            a_data_stop: assert property (p_data_stop) else $error("Error bit lost.");

            property p_co_stop;
                ce && err_cause_in[g][ERR_CO_STOP_BIT]
                    |=> state_reg.error_cause[g][ERR_CO_STOP_BIT];
            endproperty
            a_co_stop: assert property (p_co_stop) else $error("Error bit lost.");

            property p_pls_ovf;
                ce && err_cause_in[g][ERR_PULSER_OVF_BIT]
                    |=> state_reg.error_cause[g][ERR_PULSER_OVF_BIT];
            endproperty
            a_pls_ovf: assert property (p_pls_ovf) else $error("Error bit lost.");

            property p_over_range;
                ce && err_cause_in[g][ERR_OVER_RANGE_BIT]
                    |=> state_reg.error_cause[g][ERR_OVER_RANGE_BIT];
            endproperty
            a_over_range: assert property (p_over_range) else $error("Error bit lost.");

            property p_phase_err;
                ce |=> ($past(err_cause_in[g][ERR_PULSER_PHASE_BIT:ERR_ENC_PHASE_BIT])
                        & ~state_reg.error_cause[g][ERR_PULSER_PHASE_BIT:ERR_ENC_PHASE_BIT])
                       == '0;
            endproperty
            a_phase_err: assert property (p_phase_err) else $error("Error bit lost.");

            property p_prereg_evt;
                ce |=> ($past(evt_cause_in[g][ST_PREREG_LAST_BIT:ST_PREREG_FIRST_BIT])
                        & ~state_reg.event_status[g][ST_PREREG_LAST_BIT:ST_PREREG_FIRST_BIT])
                       == '0;
            endproperty
            a_prereg_evt: assert property (p_prereg_evt) else $error("Event bit lost.");

            property p_cmp_evt;
                ce |=> ($past(evt_cause_in[g][ST_CMP_LAST_BIT:ST_CMP_FIRST_BIT])
                        & ~state_reg.event_status[g][ST_CMP_LAST_BIT:ST_CMP_FIRST_BIT])
                       == '0;
            endproperty
            a_cmp_evt: assert property (p_cmp_evt) else $error("Event bit lost.");

            property p_clear_evt;
                ce && evt_cause_in[g][ST_CLEAR_BIT]
                    |=> state_reg.event_status[g][ST_CLEAR_BIT];
            endproperty
            a_clear_evt: assert property (p_clear_evt) else $error("Event bit lost.");

            property p_latch_evt;
                ce |=> ($past(evt_cause_in[g][ST_ORIGIN_BIT:ST_LATCH_BIT])
                        & ~state_reg.event_status[g][ST_ORIGIN_BIT:ST_LATCH_BIT])
                       == '0;
            endproperty
            a_latch_evt: assert property (p_latch_evt) else $error("Event bit lost.");

            property p_slow_evt;
                ce && evt_cause_in[g][ST_SLOW_DOWN_BIT]
                    |=> state_reg.event_status[g][ST_SLOW_DOWN_BIT];
            endproperty
            a_slow_evt: assert property (p_slow_evt) else $error("Event bit lost.");

            property p_enable_wr;
                ce && wr_en[g]
                    |=> state_reg.event_enable[g] == $past(cmd_wdata[EN_W-1:0]);
            endproperty
            a_enable_wr: assert property (p_enable_wr) else $error("Enable not written.");

            property p_err_flag;
                ce |=> err_flag[g] == (|state_reg.error_cause[g]);
            endproperty
            a_err_flag: assert property (p_err_flag) else $error("Error flag wrong.");
        end
    endgenerate

endmodule : aic_axis_interrupt_cause

// ---- tb/aic_axis_interrupt_cause_bench.sv ----
// Self-checking bench for the per-axis interrupt cause logic.
// Assumes the design package and one 125 MHz clock; ce drops once to test freezing.
`timescale 1ns/10ps
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin fail_count++; \
    $display("FAIL t=%0t got %0h exp %0h", $time, got, exp); end end
module aic_axis_interrupt_cause_bench;
    import aic_pkg::*;
    // ------------------------------------------------------------------
    // Signals and design
    // ------------------------------------------------------------------
    logic                            clk          = 1'b0;
    logic                            reset        = 1'b1;
    logic                            ce           = 1'b1;
    logic [NUM_AXES-1:0][ERR_W-1:0]  err_cause_in = '0;
    logic [NUM_AXES-1:0][STAT_W-1:0] evt_cause_in = '0;
    logic                            cmd_valid    = 1'b0;
    logic [AXIS_W-1:0]               cmd_axis     = '0;
    logic [CMD_W-1:0]                cmd_code     = '0;
    logic [DATA_W-1:0]               cmd_wdata    = '0;
    logic                            rd_valid;
    logic [DATA_W-1:0]               rd_data;
    logic [NUM_AXES-1:0]             err_flag;
    logic [NUM_AXES-1:0]             evt_flag;
    logic                            int_n;
    int                              fail_count   = 0;
    int                              checks       = 0;

    always #4 clk = ~clk;

    aic_axis_interrupt_cause dut_u (
        .clk(clk), .reset(reset), .ce(ce), .err_cause_in(err_cause_in),
        .evt_cause_in(evt_cause_in), .cmd_valid(cmd_valid), .cmd_axis(cmd_axis),
        .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .rd_valid(rd_valid),
        .rd_data(rd_data), .err_flag(err_flag), .evt_flag(evt_flag), .int_n(int_n)
    );

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic print_verdict;
        $display("checks=%0d fail_count=%0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : print_verdict

    task automatic wr(input int a, input logic [7:0] code, input logic [31:0] data);
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_axis  <= a[1:0];
        cmd_code  <= code;
        cmd_wdata <= data;
        @(posedge clk);
        cmd_valid <= 1'b0;
    endtask : wr

    task automatic rd(input int a, input logic [7:0] code, input logic [31:0] exp);
        wr(a, code, 32'h0);
        #1;
        `CHK(rd_valid, 1'b1)
        `CHK(rd_data, exp)
    endtask : rd

    task automatic cause(input int a, input bit err, input int b, input logic exp_n,
                         input bit clean);
        @(posedge clk);
        if (err) err_cause_in[a][b] <= 1'b1;
        else evt_cause_in[a][b] <= 1'b1;
        @(posedge clk);
        err_cause_in <= '0;
        evt_cause_in <= '0;
        #1;
        if (clean) `CHK(int_n, 1'b1)
        @(posedge clk);
        #1;
        `CHK(int_n, exp_n)
    endtask : cause

    task automatic idle_high;
        @(posedge clk);
        #1;
        `CHK(int_n, 1'b1)
    endtask : idle_high

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset;
        `CHK({int_n, rd_valid, err_flag, evt_flag}, 10'h200)
        for (int a = 0; a < NUM_AXES; a++) begin
            rd(a, CMD_RD_ERR_CAUSE, 32'h0);
            rd(a, CMD_RD_EVT_STATUS, 32'h0);
        end
    endtask : t_reset

    task automatic t_errors;
        for (int b = 0; b < ERR_W; b++) begin
            cause(b % 4, 1'b1, b, (b == 11) ? 1'b1 : 1'b0, 1'b1);
            rd(b % 4, CMD_RD_ERR_CAUSE, (b == 11) ? 32'h0 : (32'h1 << b));
            idle_high();
        end
    endtask : t_errors

    task automatic t_events;
        wr(0, CMD_WR_EVT_ENABLE, 32'h0);
        wr(1, CMD_WR_EVT_ENABLE, 32'h7ffff);
        for (int b = 0; b < STAT_W; b++) begin
            cause(0, 1'b0, b, 1'b1, 1'b1);
            `CHK(evt_flag, 4'h0)
            rd(0, CMD_RD_EVT_STATUS, 32'h1 << b);
            cause(1, 1'b0, b, 1'b0, 1'b1);
            `CHK(evt_flag, 4'h2)
            rd(1, CMD_RD_EVT_STATUS, 32'h1 << b);
            idle_high();
        end
    endtask : t_events

    task automatic t_pair;
        wr(2, CMD_WR_EVT_ENABLE, 32'h1 << EN_DIR_BIT);
        cause(2, 1'b0, ST_DIR_MINUS, 1'b0, 1'b1);
        rd(2, CMD_RD_EVT_STATUS, 32'h1 << ST_DIR_MINUS);
        wr(2, CMD_WR_EVT_ENABLE, 32'h1 << EN_START_BIT);
        cause(2, 1'b0, ST_DIR_MINUS, 1'b1, 1'b1);
        rd(2, CMD_RD_EVT_STATUS, 32'h1 << ST_DIR_MINUS);
        cause(2, 1'b0, ST_START_BIT, 1'b0, 1'b1);
        rd(2, CMD_RD_EVT_STATUS, 32'h1 << ST_START_BIT);
        idle_high();
    endtask : t_pair

    task automatic t_axes;
        cause(1, 1'b1, 5, 1'b0, 1'b1);
        cause(2, 1'b1, 9, 1'b0, 1'b0);
        `CHK(err_flag, 4'h6)
        rd(1, CMD_RD_ERR_CAUSE, 32'h1 << 5);
        rd(3, CMD_RD_ERR_CAUSE, 32'h0);
        `CHK(int_n, 1'b0)
        rd(2, CMD_RD_ERR_CAUSE, 32'h1 << 9);
        idle_high();
    endtask : t_axes

    task automatic t_mask;
        wr(0, CMD_WR_ENV_ONE, 32'h1 << ENV_INTMASK_BIT);
        cause(0, 1'b1, 7, 1'b1, 1'b1);
        `CHK(err_flag[0], 1'b1)
        wr(0, CMD_WR_ENV_ONE, 32'h0);
        @(posedge clk);
        #1;
        `CHK(int_n, 1'b0)
        rd(0, CMD_RD_ERR_CAUSE, 32'h1 << 7);
        idle_high();
    endtask : t_mask

    task automatic t_race;
        @(posedge clk);
        err_cause_in[3][0] <= 1'b1;
        cmd_valid          <= 1'b1;
        cmd_axis           <= 2'd3;
        cmd_code           <= CMD_RD_ERR_CAUSE;
        @(posedge clk);
        err_cause_in <= '0;
        cmd_valid    <= 1'b0;
        #1;
        `CHK(rd_data, 32'h0)
        rd(3, CMD_RD_ERR_CAUSE, 32'h1);
        wr(3, 8'h00, 32'h0);
        #1;
        `CHK(rd_valid, 1'b0)
        idle_high();
    endtask : t_race

    task automatic t_freeze;
        @(posedge clk);
        ce                 <= 1'b0;
        err_cause_in[0][0] <= 1'b1;
        cmd_valid          <= 1'b1;
        cmd_axis           <= 2'd0;
        cmd_code           <= CMD_RD_ERR_CAUSE;
        repeat (2) @(posedge clk);
        ce           <= 1'b1;
        err_cause_in <= '0;
        cmd_valid    <= 1'b0;
        #1;
        `CHK(rd_valid, 1'b0)
        `CHK(err_flag, 4'h0)
        @(posedge clk);
        #1;
        `CHK(int_n, 1'b1)
        rd(0, CMD_RD_ERR_CAUSE, 32'h0);
    endtask : t_freeze

    // ------------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------------
    initial begin
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        #1;
        t_reset();
        t_errors();
        t_events();
        t_pair();
        t_axes();
        t_mask();
        t_race();
        t_freeze();
        print_verdict();
    end

    initial begin
        repeat (5000) @(posedge clk);
        fail_count++;
        print_verdict();
    end
endmodule : aic_axis_interrupt_cause_bench
